// *** sarh_pkg.sv ***
// Constants shared by the converter host controller
// Notes on behaviour
// - Normal acquisition at least 0.5 us
// - Acquisition after nap at least 0.8 us
// - Abort only within 1000 ns of start
// - Start held 5 ns before select rises
// - Power-down pulse at least 60 ns
// - Interface quiet 30 ns before start
// - Interface quiet 10 ns after start
// - Interface quiet 600 ns before busy falls
// - Select/frame fall away from busy fall
// - Other input pulses at least 10 ns
package sarh_pkg;
  localparam int CLK_NS = 20;
  localparam int ACQ_NORM_NS = 500;
  localparam int ACQ_NAP_NS = 800;
  localparam int ABORT_MAX_NS = 1000;
  localparam int START_SU_NS = 5;
  localparam int PD_PULSE_NS = 60;
  localparam int QUIET_PRE_NS = 30;
  localparam int QUIET_POST_NS = 10;
  localparam int QUIET_CONV_NS = 600;
  localparam int PULSE_MIN_NS = 10;
  localparam int BUSY_GUARD_NS = 20;
  localparam int WAKE_NS = 300;
  localparam int CONV_MAX_NS = 1160;
  localparam int ACQ_NORM_CYC = (ACQ_NORM_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_NAP_CYC = (ACQ_NAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_MAX_CYC = ABORT_MAX_NS / CLK_NS;
  localparam int START_SU_CYC = (START_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_CYC = (PD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int QPRE_CYC = (QUIET_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int QPOST_CYC = (QUIET_POST_NS + CLK_NS - 1) / CLK_NS;
  localparam int QCONV_CYC = (QUIET_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_BITS = 16;
  localparam logic [7:0] SCLK_HALF = 8'h04;
  typedef enum logic [2:0] {
    SARH_IDLE = 3'b000,
    SARH_ACQ = 3'b001,
    SARH_START = 3'b011,
    SARH_CONV = 3'b010,
    SARH_READ = 3'b110,
    SARH_PD = 3'b111
  } sarh_state_t;
endpackage

// *** sarh_fifo.sv ***
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sarh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;
  always_comb begin
    push = in_valid_i && (cnt_ff != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_ff != '0);
    nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end
  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
endmodule

// *** sarh_host.sv ***
// Host controller driving the converter pins and collecting results
`timescale 1ns/1ns
module sarh_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic nap_i,
  input wire logic abort_i,
  input wire logic pd_req_i,
  input wire logic busy_i,
  input wire logic sdo_i,
  output logic conversion_start_input_o,
  output logic cs_n_o,
  output logic frame_sync_input_o,
  output logic sclk_o,
  output logic powerdown_reset_input_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [15:0] res_data_o,
  output logic idle_o
);
  logic [1:0] busy_sy_ff, sdo_sy_ff;
  logic busy_d_ff;
  sarh_pkg::sarh_state_t st_ff, nxt_st;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [10:0] since_ff, nxt_since;
  logic napped_ff, nxt_napped;
  logic [6:0] acq_len_ff, nxt_acq_len;
  logic start_ff, nxt_start, cs_ff, nxt_cs, fs_ff, nxt_fs, sclk_ff, nxt_sclk, pd_ff, nxt_pd;
  logic [4:0] bit_ff, nxt_bit;
  logic [15:0] sh_ff, nxt_sh;
  logic [7:0] div_ff, nxt_div;
  logic push, fifo_rdy, fifo_v, busy_s, busy_fall;
  logic [15:0] fifo_d;
  logic rv_ff, nxt_rv, idle_ff, nxt_idle;
  logic [15:0] rd_ff, nxt_rd;
  assign busy_s = busy_sy_ff[1];
  assign busy_fall = busy_d_ff && !busy_s;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_sy_ff <= 2'h0;
      sdo_sy_ff <= 2'h0;
      busy_d_ff <= 1'b0;
    end else begin
      busy_sy_ff <= {busy_sy_ff[0], busy_i};
      sdo_sy_ff <= {sdo_sy_ff[0], sdo_i};
      busy_d_ff <= busy_s;
    end
  end
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = (cnt_ff != 11'h0) ? cnt_ff - 11'h1 : 11'h0;
    nxt_since = (since_ff != 11'h7ff) ? since_ff + 11'h1 : since_ff;
    nxt_napped = napped_ff;
    nxt_start = start_ff;
    nxt_cs = cs_ff;
    nxt_fs = 1'b0;
    nxt_sclk = sclk_ff;
    nxt_pd = pd_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_div = div_ff;
    push = 1'b0;
    unique case (st_ff)
      sarh_pkg::SARH_IDLE: begin
        nxt_cs = 1'b1;
        if (pd_req_i) begin
          nxt_st = sarh_pkg::SARH_PD;
          nxt_pd = 1'b1;
          nxt_cnt = 11'(sarh_pkg::PD_CYC);
        end else if (req_i && fifo_rdy) begin
          nxt_st = sarh_pkg::SARH_ACQ;
          nxt_napped = nap_i;
          nxt_cnt = nap_i ? 11'(sarh_pkg::ACQ_NAP_CYC) : 11'(sarh_pkg::ACQ_NORM_CYC);
        end
      end
      sarh_pkg::SARH_ACQ: begin
        if (cnt_ff == 11'h0 && since_ff >= 11'(sarh_pkg::QPRE_CYC)) begin
          nxt_st = sarh_pkg::SARH_START;
          nxt_cs = 1'b0;
          nxt_start = 1'b1;
          nxt_cnt = 11'(sarh_pkg::PULSE_CYC + sarh_pkg::START_SU_CYC);
        end
      end
      sarh_pkg::SARH_START: begin
        if (cnt_ff == 11'h0) begin
          nxt_cs = 1'b1;
          nxt_st = sarh_pkg::SARH_CONV;
          nxt_cnt = 11'(sarh_pkg::CONV_MAX_CYC + 4);
          nxt_since = 11'h0;
        end
      end
      sarh_pkg::SARH_CONV: begin
        nxt_start = 1'b0;
        // Hold select high and frame sync low through conversion
        // Count restarts as select rises three cycles after start rises, and again as start falls one cycle later
        if (abort_i && (since_ff + 11'h5) <= 11'(sarh_pkg::ABORT_MAX_CYC)) begin
          nxt_cs = 1'b0;
          nxt_st = sarh_pkg::SARH_IDLE;
        end else if (busy_fall || cnt_ff == 11'h0) begin
          nxt_st = sarh_pkg::SARH_READ;
          nxt_cs = 1'b0;
          nxt_bit = 5'h0;
          nxt_div = sarh_pkg::SCLK_HALF;
          nxt_sclk = 1'b0;
        end
      end
      sarh_pkg::SARH_READ: begin
        nxt_div = (div_ff != 8'h0) ? div_ff - 8'h1 : sarh_pkg::SCLK_HALF;
        if (div_ff == 8'h0) begin
          nxt_sclk = !sclk_ff;
          if (sclk_ff) begin
            nxt_sh = {sh_ff[14:0], sdo_sy_ff[1]};
            nxt_bit = bit_ff + 5'h1;
            if (bit_ff == 5'(sarh_pkg::RES_BITS - 1)) begin
              push = 1'b1;
              nxt_cs = 1'b1;
              nxt_sclk = 1'b0;
              nxt_st = sarh_pkg::SARH_IDLE;
            end
          end
        end
      end
      sarh_pkg::SARH_PD: begin
        if (cnt_ff == 11'h0) begin
          nxt_pd = 1'b0;
          nxt_st = sarh_pkg::SARH_IDLE;
        end
      end
      default: nxt_st = sarh_pkg::SARH_IDLE;
    endcase
    if (nxt_cs != cs_ff || nxt_sclk != sclk_ff || nxt_start != start_ff) begin
      nxt_since = 11'h0;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= sarh_pkg::SARH_IDLE;
      cnt_ff <= 11'h0;
      since_ff <= 11'h0;
      napped_ff <= 1'b0;
      start_ff <= 1'b0;
      cs_ff <= 1'b1;
      fs_ff <= 1'b0;
      sclk_ff <= 1'b0;
      pd_ff <= 1'b0;
      bit_ff <= 5'h0;
      sh_ff <= 16'h0;
      div_ff <= 8'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      since_ff <= nxt_since;
      napped_ff <= nxt_napped;
      start_ff <= nxt_start;
      cs_ff <= nxt_cs;
      fs_ff <= nxt_fs;
      sclk_ff <= nxt_sclk;
      pd_ff <= nxt_pd;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      div_ff <= nxt_div;
    end
  end
  sarh_fifo #(.WIDTH(16), .DEPTH(8)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i({sh_ff[14:0], sdo_sy_ff[1]}),
    .out_valid_o(fifo_v),
    .out_ready_i(!rv_ff),
    .out_data_o(fifo_d)
  );
  always_comb begin
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    if (rv_ff && res_ready_i) begin
      nxt_rv = 1'b0;
    end
    if (!rv_ff && fifo_v) begin
      nxt_rv = 1'b1;
      nxt_rd = fifo_d;
    end
    nxt_idle = (nxt_st == sarh_pkg::SARH_IDLE);
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rv_ff <= 1'b0;
      rd_ff <= 16'h0;
      idle_ff <= 1'b1;
    end else begin
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      idle_ff <= nxt_idle;
    end
  end
  assign conversion_start_input_o = start_ff;
  assign cs_n_o = cs_ff;
  assign frame_sync_input_o = fs_ff;
  assign sclk_o = sclk_ff;
  assign powerdown_reset_input_o = pd_ff;
  assign res_valid_o = rv_ff;
  assign res_data_o = rd_ff;
  assign idle_o = idle_ff;
  // Counts acquisition cycles so the start spacing can be checked
  always_comb begin
    nxt_acq_len = acq_len_ff;
    if (st_ff != sarh_pkg::SARH_ACQ) begin
      nxt_acq_len = 7'h0;
    end else if (acq_len_ff != 7'h7f) begin
      nxt_acq_len = acq_len_ff + 7'h1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acq_len_ff <= 7'h0;
    end else begin
      acq_len_ff <= nxt_acq_len;
    end
  end
  property p_pd_width;
    @(posedge clk_i) disable iff (rst_i) $rose(pd_ff) |-> pd_ff [*3];
  endproperty
  a_pd_width: assert property (p_pd_width) else $error("power-down pulse too short");
  property p_acq;
    @(posedge clk_i) disable iff (rst_i) ($rose(start_ff) && !napped_ff)
      |-> acq_len_ff >= 7'(sarh_pkg::ACQ_NORM_CYC);
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition too short");
  property p_acq_nap;
    @(posedge clk_i) disable iff (rst_i) ($rose(start_ff) && napped_ff)
      |-> acq_len_ff >= 7'(sarh_pkg::ACQ_NAP_CYC);
  endproperty
  a_acq_nap: assert property (p_acq_nap) else $error("nap acquisition too short");
  property p_start_qual;
    @(posedge clk_i) disable iff (rst_i) $rose(start_ff) |-> !cs_ff;
  endproperty
  a_start_qual: assert property (p_start_qual) else $error("start without select");
  property p_start_su;
    @(posedge clk_i) disable iff (rst_i) ($rose(cs_ff) && $past(st_ff) == sarh_pkg::SARH_START)
      |-> start_ff && $past(start_ff);
  endproperty
  a_start_su: assert property (p_start_su) else $error("start not ahead of select rise");
  property p_start_width;
    @(posedge clk_i) disable iff (rst_i) $rose(start_ff) |-> start_ff [*2];
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse too short");
  property p_quiet_pre;
    @(posedge clk_i) disable iff (rst_i) $rose(start_ff) |-> $past(since_ff) >= 11'(sarh_pkg::QPRE_CYC);
  endproperty
  a_quiet_pre: assert property (p_quiet_pre) else $error("interface not quiet before start");
  property p_conv_quiet;
    @(posedge clk_i) disable iff (rst_i) (st_ff == sarh_pkg::SARH_CONV && $past(st_ff) == sarh_pkg::SARH_CONV)
      |-> $stable(sclk_ff) && !fs_ff;
  endproperty
  a_conv_quiet: assert property (p_conv_quiet) else $error("toggle during conversion");
endmodule

// *** sarh_dev_model.sv ***
// Behavioural converter model facing the host controller
`timescale 1ns/1ns
module sarh_dev_model #(
  parameter int CONV_NS = 1000,
  parameter logic [15:0] BASE = 16'ha5c3
) (
  input wire logic start_i,
  input wire logic cs_n_i,
  input wire logic fs_i,
  input wire logic sclk_i,
  input wire logic pd_i,
  input wire logic nap_i,
  output logic busy_o = 1'b0,
  output logic sdo_o,
  output int err_o = 0
);
  logic [15:0] res = 16'h0;
  logic last = 1'b0;
  logic ab = 1'b0;
  int n = 0;
  int idx = 15;
  // Start far in the past so the first pin settling after reset is no false pulse
  realtime t_end = -1000, t_st = -1000, t_pd = -1000, t_tog = -1000, t_cs = -1000;
  wire qual = start_i & ~cs_n_i;
  // Released data line shows the inverse of its last bit
  assign sdo_o = (cs_n_i && !(fs_i && !busy_o)) ? ~last : res[idx];
  always @(posedge start_i) t_st = $realtime;
  always @(negedge start_i) if ($realtime - t_st < 10) err_o++;
  always @(sclk_i or fs_i or pd_i) t_tog = $realtime;
  always @(posedge pd_i) t_pd = $realtime;
  always @(negedge pd_i) begin
    if ($realtime - t_pd < 60) err_o++;
    busy_o = 1'b0;
  end
  always @(posedge cs_n_i) begin
    if (start_i && $realtime - t_st < 5) err_o++;
    if ($realtime - t_cs < 10) err_o++;
    last = res[idx];
    t_cs = $realtime;
  end
  always @(negedge cs_n_i) begin
    if (busy_o && $realtime - t_st <= 1000) ab = 1'b1;
    if (!busy_o && $realtime - t_end < 15) err_o++;
    idx = 15;
    t_cs = $realtime;
  end
  always @(negedge sclk_i) if (!cs_n_i && idx > 0) #2 idx--;
  always @(posedge qual) begin
    if (!busy_o) begin
      if ($realtime - t_end < (nap_i ? 800 : 500)) err_o++;
      if ($realtime - t_tog < 30) err_o++;
      // Busy edges land off the host clock edges
      #15 busy_o = 1'b1;
      for (int k = 0; k < CONV_NS && !ab; k++) #1;
      if (!ab) begin
        if ($realtime - t_cs < 600 || $realtime - t_tog < 600) err_o++;
        res = BASE ^ 16'(n);
        n++;
        idx = 15;
      end
      busy_o = 1'b0;
      t_end = $realtime;
      ab = 1'b0;
    end
  end
endmodule

// *** sarh_host_bench.sv ***
// Testbench for the converter host controller
`timescale 1ns/1ns
module sarh_host_bench;
  localparam logic [15:0] BASE = 16'h5a3c;
  logic clk_i = 0, rst_i = 1, req_i = 0, nap_i = 0, abort_i = 0, pd_req_i = 0, res_ready_i = 0;
  logic busy, serial_result_output, start, cs_n, fs, sclk, pd, vld, idle;
  logic [15:0] data;
  logic [4:0] mon;
  int failures = 0, checks_done = 0, nres = 0, err;
  assign mon = {idle, start, busy, pd, vld};
  always #10 clk_i = ~clk_i;
  sarh_host DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .nap_i(nap_i), .abort_i(abort_i),
    .pd_req_i(pd_req_i), .busy_i(busy), .sdo_i(serial_result_output), .conversion_start_input_o(start), .cs_n_o(cs_n),
    .frame_sync_input_o(fs), .sclk_o(sclk), .powerdown_reset_input_o(pd), .res_valid_o(vld),
    .res_ready_i(res_ready_i), .res_data_o(data), .idle_o(idle));
  sarh_dev_model #(.BASE(BASE)) MDL (.start_i(start), .cs_n_i(cs_n), .fs_i(fs), .sclk_i(sclk),
    .pd_i(pd), .nap_i(nap_i), .busy_o(busy), .sdo_o(serial_result_output), .err_o(err));
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_mon(int b, logic v, int lim, output int n);
    for (n = 0; n < lim && mon[b] !== v; n++) @(negedge clk_i);
    chk("wait_level", {15'h0, mon[b]}, {15'h0, v});
  endtask
  task automatic pop(bit check);
    int n;
    wait_mon(0, 1'b1, 400, n);
    if (check) chk("result", data, BASE ^ 16'(nres));
    if (check) nres++;
    res_ready_i = 1;
    @(negedge clk_i);
    res_ready_i = 0;
  endtask
  task automatic convert(logic nap, output int lat);
    int n;
    nap_i = nap;
    req_i = 1;
    wait_mon(4, 1'b0, 10, n);
    req_i = 0;
    wait_mon(3, 1'b1, 60, lat);
    wait_mon(4, 1'b1, 400, n);
  endtask
  task automatic done(string name);
    chk("device_rules", err[15:0], 16'h0);
    chk("idle_pins", {13'h0, cs_n, sclk, fs}, 16'h4);
    $display("test %s done", name);
  endtask
  task automatic t_normal();
    int lat;
    convert(1'b0, lat);
    chk("acq_normal", {15'h0, lat >= sarh_pkg::ACQ_NORM_CYC}, 16'h1);
    pop(1'b1);
    done("normal");
  endtask
  task automatic t_nap();
    int lat;
    convert(1'b1, lat);
    chk("acq_nap", {15'h0, lat >= sarh_pkg::ACQ_NAP_CYC}, 16'h1);
    nap_i = 0;
    pop(1'b1);
    done("nap");
  endtask
  task automatic t_abort();
    int n;
    req_i = 1;
    wait_mon(4, 1'b0, 10, n);
    req_i = 0;
    wait_mon(2, 1'b1, 60, n);
    repeat (5) @(negedge clk_i);
    abort_i = 1;
    wait_mon(2, 1'b0, 12, n);
    abort_i = 0;
    wait_mon(4, 1'b1, 400, n);
    repeat (10) @(negedge clk_i);
    while (vld === 1'b1) pop(1'b0);
    done("abort");
  endtask
  task automatic t_late_abort();
    int n;
    req_i = 1;
    wait_mon(4, 1'b0, 10, n);
    req_i = 0;
    wait_mon(2, 1'b1, 60, n);
    repeat (50) @(negedge clk_i);
    abort_i = 1;
    repeat (2) @(negedge clk_i);
    abort_i = 0;
    wait_mon(4, 1'b1, 400, n);
    pop(1'b1);
    done("late_abort");
  endtask
  task automatic t_pd();
    int n, w;
    pd_req_i = 1;
    wait_mon(1, 1'b1, 10, n);
    pd_req_i = 0;
    wait_mon(1, 1'b0, 20, w);
    chk("pd_width", {15'h0, w >= sarh_pkg::PD_CYC}, 16'h1);
    wait_mon(4, 1'b1, 20, n);
    done("powerdown");
  endtask
  task automatic t_fifo();
    int lat;
    // Eight words queue and one more waits in the output register
    for (int i = 0; i < 9; i++) convert(1'b0, lat);
    req_i = 1;
    repeat (60) @(negedge clk_i);
    chk("full_refused", {14'h0, idle, start}, 16'h2);
    req_i = 0;
    for (int i = 0; i < 9; i++) begin
      repeat (3) @(negedge clk_i);
      pop(1'b1);
    end
    repeat (4) @(negedge clk_i);
    chk("fifo_empty", {15'h0, vld}, 16'h0);
    done("fifo");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 0;
    @(negedge clk_i);
    t_normal();
    t_nap();
    t_abort();
    t_late_abort();
    t_pd();
    t_fifo();
    results();
  end
  // Limit far above the expected run of a few thousand cycles
  initial begin
    #1000000;
    failures++;
    results();
  end
endmodule
